//--- logic/rxcb_map.svh
// register offsets, field positions, reset values and timing counts of the rx config bank
// assumes a byte-wide register port with word-less byte addressing
//
// Operation
// - bit rate equals xtal over 64(C+1)
// - bit rate divisor resets to 7
// - ook floor level byte, resets 0x0c
// - fifo depth code 16/32/48/64 bytes
// - set select picks first or second dividers
`ifndef RXCB_MAP_SVH
`define RXCB_MAP_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define RXCB_ADDR_W          4
`define RXCB_OFS_CTRL        4'h_2
`define RXCB_OFS_BIT_RATE    4'h_3
`define RXCB_OFS_OOK_FLOOR   4'h_4
`define RXCB_OFS_FIFO_CFG    4'h_5
`define RXCB_OFS_REF1        4'h_6
`define RXCB_OFS_P1          4'h_7
`define RXCB_OFS_S1          4'h_8
`define RXCB_OFS_REF2        4'h_9
`define RXCB_OFS_P2          4'h_a
`define RXCB_OFS_S2          4'h_b
`define RXCB_OFS_RSVD        4'h_c

// ----------------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------------
`define RXCB_BR_MSB          6
`define RXCB_FIFO_SIZE_MSB   7
`define RXCB_FIFO_SIZE_LSB   6
`define RXCB_FIFO_THR_MSB    5
`define RXCB_SET_SEL_BIT     0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RXCB_RST_CTRL        8'h_00
`define RXCB_RST_BIT_RATE    8'h_07
`define RXCB_RST_OOK_FLOOR   8'h_0c
`define RXCB_RST_FIFO_CFG    8'h_0f
`define RXCB_RST_REF1        8'h_00
`define RXCB_RST_P1          8'h_64
`define RXCB_RST_S1          8'h_32
`define RXCB_RST_REF2        8'h_00
`define RXCB_RST_P2          8'h_62
`define RXCB_RST_S2          8'h_00
`define RXCB_RST_RSVD        8'h_38

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RXCB_BIT_PRESCALE    7'h_40

`endif

//--- logic/rxcb_pkg.sv
// types of the rx config bank
// assumes nothing beyond the map header
package rxcb_pkg;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] bit_rate;
    logic [7:0] ook_floor;
    logic [7:0] fifo_cfg;
    logic [7:0] ref1;
    logic [7:0] p1;
    logic [7:0] s1;
    logic [7:0] ref2;
    logic [7:0] p2;
    logic [7:0] s2;
    logic [7:0] rdata;
    logic [5:0] pre_cnt;
    logic [6:0] div_cnt;
    logic       bit_tick;
    logic [6:0] fifo_depth;
    logic [7:0] ref_act;
    logic [7:0] p_act;
    logic [7:0] s_act;
  } rxcb_state_type;
endpackage

//--- logic/rxcb_bank.sv
// rx configuration bank: bit rate divisor, ook floor, fifo sizing, two pll divider sets
// assumes a synchronous host port on i_clk_sys and the xtal-derived system clock
`include "rxcb_map.svh"
`timescale 1ns/100ps
`default_nettype none

module rxcb_bank
  import rxcb_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // configuration outputs
  output logic            o_bit_tick,
  output logic      [7:0] o_ook_floor_level,
  output logic      [6:0] o_fifo_depth,
  output logic      [5:0] o_fifo_thresh,
  output logic      [7:0] o_ref_divider,
  output logic      [7:0] o_p_divider,
  output logic      [7:0] o_s_divider,
  output logic            o_divider_set_select
);

  rxcb_state_type st_r;
  rxcb_state_type st_nxt;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.bit_tick = 1'b0;
    st_nxt.rdata    = 8'h_00;
    if (i_wr) begin
      case (i_addr)
        `RXCB_OFS_CTRL:      st_nxt.ctrl      = {7'h_00, i_wdata[`RXCB_SET_SEL_BIT]};
        `RXCB_OFS_BIT_RATE:  st_nxt.bit_rate  = {1'b0, i_wdata[`RXCB_BR_MSB:0]};
        `RXCB_OFS_OOK_FLOOR: st_nxt.ook_floor = i_wdata;
        `RXCB_OFS_FIFO_CFG:  st_nxt.fifo_cfg  = i_wdata;
        `RXCB_OFS_REF1:      st_nxt.ref1      = i_wdata;
        `RXCB_OFS_P1:        st_nxt.p1        = i_wdata;
        `RXCB_OFS_S1:        st_nxt.s1        = i_wdata;
        `RXCB_OFS_REF2:      st_nxt.ref2      = i_wdata;
        `RXCB_OFS_P2:        st_nxt.p2        = i_wdata;
        `RXCB_OFS_S2:        st_nxt.s2        = i_wdata;
        default:             st_nxt.ctrl      = st_r.ctrl;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `RXCB_OFS_CTRL:      st_nxt.rdata = st_r.ctrl;
        `RXCB_OFS_BIT_RATE:  st_nxt.rdata = st_r.bit_rate;
        `RXCB_OFS_OOK_FLOOR: st_nxt.rdata = st_r.ook_floor;
        `RXCB_OFS_FIFO_CFG:  st_nxt.rdata = st_r.fifo_cfg;
        `RXCB_OFS_REF1:      st_nxt.rdata = st_r.ref1;
        `RXCB_OFS_P1:        st_nxt.rdata = st_r.p1;
        `RXCB_OFS_S1:        st_nxt.rdata = st_r.s1;
        `RXCB_OFS_REF2:      st_nxt.rdata = st_r.ref2;
        `RXCB_OFS_P2:        st_nxt.rdata = st_r.p2;
        `RXCB_OFS_S2:        st_nxt.rdata = st_r.s2;
        `RXCB_OFS_RSVD:      st_nxt.rdata = `RXCB_RST_RSVD;
        default:             st_nxt.rdata = 8'h_00;
      endcase
    end
    // bit clock: prescale by 64, then by divisor plus one
    if (st_r.pre_cnt == 6'(`RXCB_BIT_PRESCALE - 7'h_01)) begin
      st_nxt.pre_cnt = 6'h_00;
      if (st_r.div_cnt >= st_r.bit_rate[6:0]) begin
        st_nxt.div_cnt  = 7'h_00;
        st_nxt.bit_tick = 1'b1;
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 7'h_01;
      end
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 6'h_01;
    end
    // fifo depth in bytes: 16 times (code plus one)
    st_nxt.fifo_depth = {1'b0, st_r.fifo_cfg[`RXCB_FIFO_SIZE_MSB:`RXCB_FIFO_SIZE_LSB], 4'h_0} + 7'h_10;
    // active divider set
    if (st_r.ctrl[`RXCB_SET_SEL_BIT]) begin
      st_nxt.ref_act = st_r.ref2;
      st_nxt.p_act   = st_r.p2;
      st_nxt.s_act   = st_r.s2;
    end else begin
      st_nxt.ref_act = st_r.ref1;
      st_nxt.p_act   = st_r.p1;
      st_nxt.s_act   = st_r.s1;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r.ctrl       <= `RXCB_RST_CTRL;
      st_r.bit_rate   <= `RXCB_RST_BIT_RATE;
      st_r.ook_floor  <= `RXCB_RST_OOK_FLOOR;
      st_r.fifo_cfg   <= `RXCB_RST_FIFO_CFG;
      st_r.ref1       <= `RXCB_RST_REF1;
      st_r.p1         <= `RXCB_RST_P1;
      st_r.s1         <= `RXCB_RST_S1;
      st_r.ref2       <= `RXCB_RST_REF2;
      st_r.p2         <= `RXCB_RST_P2;
      st_r.s2         <= `RXCB_RST_S2;
      st_r.rdata      <= 8'h_00;
      st_r.pre_cnt    <= 6'h_00;
      st_r.div_cnt    <= 7'h_00;
      st_r.bit_tick   <= 1'b0;
      st_r.fifo_depth <= 7'h_10;
      st_r.ref_act    <= `RXCB_RST_REF1;
      st_r.p_act      <= `RXCB_RST_P1;
      st_r.s_act      <= `RXCB_RST_S1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_rdata              = st_r.rdata;
  assign o_bit_tick           = st_r.bit_tick;
  assign o_ook_floor_level    = st_r.ook_floor;
  assign o_fifo_depth         = st_r.fifo_depth;
  assign o_fifo_thresh        = st_r.fifo_cfg[`RXCB_FIFO_THR_MSB:0];
  assign o_ref_divider        = st_r.ref_act;
  assign o_p_divider          = st_r.p_act;
  assign o_s_divider          = st_r.s_act;
  assign o_divider_set_select = st_r.ctrl[`RXCB_SET_SEL_BIT];

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // helper: cycles since the last tick, valid only while the divisor held still
  logic [13:0] gap_r;
  logic        gap_ok_r;
  logic [7:0]  gap_rate_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      gap_r      <= 14'h_0000;
      gap_ok_r   <= 1'b0;
      gap_rate_r <= 8'h_00;
    end else if (o_bit_tick) begin
      gap_r      <= 14'h_0001;
      gap_ok_r   <= 1'b1;
      gap_rate_r <= st_r.bit_rate;
    end else begin
      gap_r      <= gap_r + 14'h_0001;
      gap_ok_r   <= gap_ok_r && (st_r.bit_rate == gap_rate_r);
    end
  end

  sequence s_sel_write(logic v);
    i_wr && i_addr == `RXCB_OFS_CTRL && i_wdata[0] == v;
  endsequence

  AST_BR_RESET: assert property (@(posedge i_clk_sys) $fell(i_sys_rst) |-> st_r.bit_rate == 8'h_07)
    else $error("bit rate divisor not 7 after reset");
  AST_BR_MASK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) st_r.bit_rate[7] == 1'b0)
    else $error("bit rate divisor exceeds 127");
  AST_BR_SPACING: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_bit_tick && gap_ok_r && st_r.bit_rate == gap_rate_r |-> gap_r == {{1'b0, st_r.bit_rate[6:0]} + 8'h_01, 6'h_00})
    else $error("bit tick spacing not 64 times divisor plus one");
  AST_OOK_WR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_wr && i_addr == `RXCB_OFS_OOK_FLOOR |=> o_ook_floor_level == $past(i_wdata))
    else $error("ook floor write lost");
  AST_DEPTH: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $stable(st_r.fifo_cfg) |=> o_fifo_depth == 7'd16 * ({5'd0, $past(st_r.fifo_cfg[7:6])} + 7'd1))
    else $error("fifo depth mismatch");
  AST_SEL_SECOND: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_sel_write(1'b1) ##1 (!i_wr)[*2] |-> o_p_divider == st_r.p2)
    else $error("second set not applied");
  AST_SEL_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    s_sel_write(1'b0) ##1 (!i_wr)[*2] |-> o_s_divider == st_r.s1)
    else $error("first set not applied");
  AST_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !(i_wr && i_addr == `RXCB_OFS_P1) |=> st_r.p1 == $past(st_r.p1))
    else $error("inactive divider changed");
  AST_RD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_rd && i_addr == `RXCB_OFS_REF2 && !i_wr |=> o_rdata == $past(st_r.ref2))
    else $error("divider readback wrong");

endmodule

`default_nettype wire

//--- tb/rxcb_host.sv
// host model driving the byte-wide register port of the rx config bank
// assumes the bank samples strobes on the rising edge of i_clk_sys
`timescale 1ns/100ps
`default_nettype none
module rxcb_host (
  // clock
  input  wire logic       i_clk_sys,
  // register port
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  initial begin
    o_addr  = 4'h_0;
    o_wdata = 8'h_00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
    // released data must not keep the last value
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/rxcb_bank_bench.sv
// self-checking bench of the rx config bank
// assumes the host model in rxcb_host.sv
`timescale 1ns/100ps
`default_nettype none
module rxcb_bank_bench;
  logic        clk, rst, wr, rd, tick, sel;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, ook, rf, pd, sd, v;
  logic [6:0]  depth;
  logic [5:0]  thr;
  logic [7:0]  shadow [16];
  logic [31:0] lfsr_r;
  int          errors, check_count, n;
  rxcb_host u_rxcb_host (.i_clk_sys(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  rxcb_bank u_rxcb_bank (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_bit_tick(tick), .o_ook_floor_level(ook), .o_fifo_depth(depth), .o_fifo_thresh(thr),
    .o_ref_divider(rf), .o_p_divider(pd), .o_s_divider(sd), .o_divider_set_select(sel));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrx(input logic [3:0] a, input logic [7:0] d);
    u_rxcb_host.wr(a, d);
    if (a == 4'h_2) shadow[a] = d & 8'h_01;
    else if (a == 4'h_3) shadow[a] = d & 8'h_7f;
    else if (a > 4'h_3 && a < 4'h_c) shadow[a] = d;
  endtask
  task automatic rdx(input logic [3:0] a);
    u_rxcb_host.rd(a, v);
    check(v, (a >= 4'h_2 && a <= 4'h_c) ? shadow[a] : 8'h_00);
  endtask
  task automatic chk_out();
    repeat (2) @(posedge clk);
    #1;
    check(ook, shadow[4]);
    check(depth, 16'(shadow[5][7:6]) * 16'h_0010 + 16'h_0010);
    check(thr, shadow[5][5:0]);
    check(sel, shadow[2][0]);
    check({rf, pd, sd}, shadow[2][0] ? {shadow[9], shadow[10], shadow[11]} : {shadow[6], shadow[7], shadow[8]});
  endtask
  task automatic period(input logic [6:0] c);
    wrx(4'h_3, {1'b0, c});
    repeat (2) @(posedge tick);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1);
    check(n, 16'(c + 1) * 16'h_0040);
  endtask
  task automatic wrap_up();
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    errors++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    lfsr_r = 32'h_a65e_522d;
    foreach (shadow[i]) shadow[i] = 8'h_00;
    shadow[3] = 8'h_07;
    shadow[4] = 8'h_0c;
    shadow[5] = 8'h_0f;
    shadow[7] = 8'h_64;
    shadow[8] = 8'h_32;
    shadow[10] = 8'h_62;
    shadow[12] = 8'h_38;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk_out();
    for (int a = 0; a < 16; a++) rdx(4'(a));
    for (int k = 0; k < 4; k++) begin
      wrx(4'h_5, {2'(k), 6'(k * 9)});
      chk_out();
    end
    wrx(4'h_c, 8'h_c7);
    rdx(4'h_c);
    for (int s = 0; s < 2; s++) begin
      for (int a = 6; a < 12; a++) begin
        lfsr_r = lfsr_next(lfsr_r);
        wrx(4'(a), lfsr_r[7:0]);
        chk_out();
      end
      wrx(4'h_2, 8'(1 - s));
      chk_out();
    end
    repeat (40) begin
      lfsr_r = lfsr_next(lfsr_r);
      wrx(lfsr_r[3:0], lfsr_r[11:4]);
      rdx(lfsr_r[15:12]);
    end
    chk_out();
    period(7'h_00);
    period(7'h_7f);
    lfsr_r = lfsr_next(lfsr_r);
    period({5'h_00, lfsr_r[1:0]});
    wrap_up();
  end
endmodule
`default_nettype wire
